// File: core/byte_alu_pkg.sv
// Constants, register map and types shared by the byte ALU block
package byte_alu_pkg;

	// ==========================================================
	// Data widths
	localparam int DATA_W = 8;
	localparam int BUS_W = 32;
	localparam int INSTR_W = 16;
	localparam int CNT_W = 16;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_FILE_PTR = 8'h0C;
	localparam logic [7:0] OFS_FILE_DATA = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_EXEC_CNT = 8'h18;

	// ==========================================================
	// Instruction word fields
	localparam int OP_LSB = 8;
	localparam int OP_W = 2;
	localparam int DEST_BIT = 7;
	localparam int FILE_AW = 7;
	localparam int NIB_W = 4;

	// ==========================================================
	// Status and result fields
	localparam int ST_CARRY = 0;
	localparam int ST_HALF = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_BUSY = 3;
	localparam int RES_DEST_BIT = 8;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// ==========================================================
	// Bus encodings
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

	// Operation codes carried in the instruction word
	typedef enum logic [1:0] {
		subtract_acc_from_reg,
		xor_acc_with_reg,
		nibble_exchange_reg,
		xor_literal_into_acc
	} alu_op_t;

endpackage

// File: core/instr_decode.sv
// Instruction word field decoder
`timescale 1ns/1ps
`default_nettype none
module instr_decode
	import byte_alu_pkg::*;
(
	input wire logic [INSTR_W-1:0] instr_in,
	output alu_op_t op_out,
	output logic dest_file_out,
	output logic [FILE_AW-1:0] file_addr_out,
	output logic [DATA_W-1:0] literal_out
);

	// ==========================================================
	// Field extraction
	// seven bit address
	assign file_addr_out = instr_in[FILE_AW-1:0];
	assign literal_out = instr_in[DATA_W-1:0];
	assign op_out = alu_op_t'(instr_in[OP_LSB +: OP_W]);

	// Literal form has no select bit; it always targets the accumulator
	always_comb begin
		case (op_out)
			xor_literal_into_acc: dest_file_out = 1'b0;
			default: dest_file_out = instr_in[DEST_BIT];
		endcase
	end

endmodule // instr_decode
`default_nettype wire

// File: core/byte_alu.sv
// Combinational 8-bit datapath for subtract, exclusive-OR and swap
`timescale 1ns/1ps
`default_nettype none
module byte_alu
	import byte_alu_pkg::*;
(
	input wire alu_op_t op_in,
	input wire logic [DATA_W-1:0] acc_in,
	input wire logic [DATA_W-1:0] file_in,
	input wire logic [DATA_W-1:0] literal_in,
	output logic [DATA_W-1:0] result_out,
	output logic carry_out,
	output logic half_carry_flag_out,
	output logic zero_out,
	output logic upd_carry_out,
	output logic upd_zero_out
);

	// ==========================================================
	// Operation select
	logic [DATA_W:0] diff;

	always_comb begin
		// Borrow-free carry: extra bit is 1 when acc <= file
		diff = {1'b0, file_in} + {1'b0, ~acc_in} + {{DATA_W{1'b0}}, 1'b1};
		result_out = '0;
		carry_out = 1'b0;
		half_carry_flag_out = 1'b0;
		upd_carry_out = 1'b0;
		upd_zero_out = 1'b0;
		case (op_in)
			subtract_acc_from_reg: begin
				result_out = diff[DATA_W-1:0];
				carry_out = diff[DATA_W];
				half_carry_flag_out = acc_in[NIB_W-1:0] <= file_in[NIB_W-1:0];
				upd_carry_out = 1'b1;
				upd_zero_out = 1'b1;
			end
			xor_acc_with_reg: begin
				result_out = acc_in ^ file_in;
				upd_zero_out = 1'b1;
			end
			xor_literal_into_acc: begin
				result_out = acc_in ^ literal_in;
				upd_zero_out = 1'b1;
			end
			default: begin
				result_out = {file_in[NIB_W-1:0], file_in[DATA_W-1:NIB_W]};
				upd_zero_out = 1'b0;
			end
		endcase
		zero_out = (result_out == '0);
	end

endmodule // byte_alu
`default_nettype wire

// File: core/byte_alu_top.sv
// AHB-Lite register front end, file storage and execution of byte operations
`timescale 1ns/1ps
`default_nettype none
module byte_alu_top
	import byte_alu_pkg::*;
#(
	parameter int FILE_DEPTH = 128
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [BUS_W-1:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [BUS_W-1:0] hrdata_out,
	output logic hresp_out,
	output logic [DATA_W-1:0] acc_out,
	output logic carry_out,
	output logic half_carry_flag_out,
	output logic zero_out,
	output logic busy_out
);

	// ==========================================================
	// Programming model, word offsets on the register bus
	// INSTR at 0x00, read and write
	// Bits 9 to 8 pick the operation
	// Code 0 subtracts accumulator from a file byte
	// Code 1 exclusive-ORs accumulator with a file byte
	// Code 2 exchanges the nibbles of a file byte
	// Code 3 exclusive-ORs a literal into the accumulator
	// Bit 7 picks the destination for codes 0 to 2
	// Bits 6 to 0 address the file byte
	// Bits 7 to 0 carry the literal for code 3
	// Every write starts exactly one execution
	// ACC at 0x04, eight bit working register
	// STATUS at 0x08, carry, half-carry, zero, busy
	// Busy is read-only; the three flags may be written
	// FILE_PTR at 0x0C, window into the file storage
	// FILE_DATA at 0x10, file byte under the pointer
	// RESULT at 0x14, last result and its destination
	// EXEC_CNT at 0x18, executed operations, wrapping
	// Other offsets read zero and drop writes

	// ==========================================================
	// Bus timing seen by a master
	// Address phase taken when selected, ready and active
	// One wait state on every transfer
	// A second wait state while an execution is due
	// The stall keeps reads from seeing stale results
	// Write data sampled at the completing edge
	// Read data loaded as ready rises, held until the next read
	// Response is always OKAY; transfer size is not checked
	// Back-to-back transfers overlap address and data phases

	// ==========================================================
	// Walk of a read from ACC
	// Edge 1: address phase taken, ready drops
	// Edge 2: ready rises with the accumulator on read data
	// Edge 3: master samples data, bus free again
	// Walk of a write to INSTR
	// Edge 1: address phase taken, ready drops
	// Edge 2: ready rises
	// Edge 3: word latched, busy rises
	// Edge 4: operation executes, busy falls
	// A read taken at edge 3 waits one cycle more

	// ==========================================================
	// Execution
	// Runs in the cycle after an instruction write lands
	// busy_out is high for exactly that one cycle; a STATUS read stalls past it and sees busy low
	// Flags the operation does not list keep their value
	// A file byte is written only when bit 7 selects it
	// Literal form ignores bit 7, which belongs to the literal
	// Software flag writes may be replaced by a later operation
	// Limitation: one execution per instruction write, no queue

	// ==========================================================
	// Flag behaviour per operation
	// Subtract: carry set when accumulator <= file byte
	// Subtract: half-carry on the low nibbles, same compare
	// Subtract: zero from the eight bit result
	// Exclusive-OR forms: zero only
	// Nibble exchange: no flag moves

	// ==========================================================
	// Reset
	// Synchronous and active high
	// Clears accumulator, flags, pointer, count and file storage
	// Ready stands high so the first transfer may follow at once
	// Clearing all file bytes costs area but keeps runs repeatable

	// ==========================================================
	// State record
	typedef struct packed {
		// Bus data phase
		logic dph;
		logic dwrite;
		logic [7:0] daddr;
		logic ready;
		logic resp;
		logic [BUS_W-1:0] rdata;
		// Working register and flags
		logic [DATA_W-1:0] acc;
		logic carry;
		logic half;
		logic zero;
		// Instruction and its execution
		logic [INSTR_W-1:0] instr;
		logic pending;
		logic [FILE_AW-1:0] file_ptr;
		logic [DATA_W-1:0] result;
		logic dest_file;
		logic [CNT_W-1:0] exec_cnt;
		// File storage
		logic [FILE_DEPTH-1:0][DATA_W-1:0] mem;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// Reset image; file contents clear as well
	localparam state_t ST_RST = '{
		dph: 1'b0,
		dwrite: 1'b0,
		daddr: '0,
		ready: 1'b1,
		resp: HRESP_OKAY,
		rdata: '0,
		acc: ACC_RST,
		carry: 1'b0,
		half: 1'b0,
		zero: 1'b0,
		instr: INSTR_RST,
		pending: 1'b0,
		file_ptr: '0,
		result: '0,
		dest_file: 1'b0,
		exec_cnt: '0,
		mem: '0
	};

	// ==========================================================
	// Helper functions
	// Word-aligned register offset; byte lane bits are ignored
	function automatic logic [7:0] reg_offset(input logic [7:0] addr);
		reg_offset = {addr[7:2], 2'b00};
	endfunction

	// Storage index from a file address, folded into the depth
	function automatic int file_index(input logic [FILE_AW-1:0] addr);
		file_index = int'(addr) % FILE_DEPTH;
	endfunction

	// Status word as software sees it
	function automatic logic [BUS_W-1:0] status_word(input state_t s);
		logic [BUS_W-1:0] w;
		w = '0;
		w[ST_CARRY] = s.carry;
		w[ST_HALF] = s.half;
		w[ST_ZERO] = s.zero;
		w[ST_BUSY] = s.pending;
		status_word = w;
	endfunction

	// Read multiplexer; unmapped offsets return zero
	function automatic logic [BUS_W-1:0] read_word(input state_t s);
		logic [BUS_W-1:0] w;
		w = '0;
		case (reg_offset(s.daddr))
			OFS_INSTR: w[INSTR_W-1:0] = s.instr;
			OFS_ACC: w[DATA_W-1:0] = s.acc;
			OFS_STATUS: w = status_word(s);
			OFS_FILE_PTR: w[FILE_AW-1:0] = s.file_ptr;
			OFS_FILE_DATA: w[DATA_W-1:0] = s.mem[file_index(s.file_ptr)];
			OFS_RESULT: begin
				w[DATA_W-1:0] = s.result;
				w[RES_DEST_BIT] = s.dest_file;
			end
			OFS_EXEC_CNT: w[CNT_W-1:0] = s.exec_cnt;
			default: w = '0;
		endcase
		read_word = w;
	endfunction

	// ==========================================================
	// Decode and datapath
	alu_op_t dec_op;
	logic dec_dest_file;
	logic [FILE_AW-1:0] dec_addr;
	logic [DATA_W-1:0] dec_literal;
	logic [DATA_W-1:0] alu_result;
	logic alu_carry;
	logic alu_half;
	logic alu_zero;
	logic alu_upd_carry;
	logic alu_upd_zero;
	logic addr_take;

	// fields split from the held word
	instr_decode u_decode (
		.instr_in(st_reg.instr),
		.op_out(dec_op),
		.dest_file_out(dec_dest_file),
		.file_addr_out(dec_addr),
		.literal_out(dec_literal)
	);

	// Operand is read from storage by the decoded address
	byte_alu u_alu (
		.op_in(dec_op),
		.acc_in(st_reg.acc),
		.file_in(st_reg.mem[file_index(dec_addr)]),
		.literal_in(dec_literal),
		.result_out(alu_result),
		.carry_out(alu_carry),
		.half_carry_flag_out(alu_half),
		.zero_out(alu_zero),
		.upd_carry_out(alu_upd_carry),
		.upd_zero_out(alu_upd_zero)
	);

	// Only word transfers are defined; size is not checked
	assign addr_take = hsel_in && hready_in && htrans_in[HTRANS_ACTIVE_BIT];

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.resp = HRESP_OKAY;

		// Execution runs one cycle after the instruction write lands
		if (st_reg.pending) begin
			st_next.pending = 1'b0;
			st_next.result = alu_result;
			st_next.dest_file = dec_dest_file;
			st_next.exec_cnt = st_reg.exec_cnt + CNT_ONE;
			if (alu_upd_carry) begin
				st_next.carry = alu_carry;
				st_next.half = alu_half;
			end
			if (alu_upd_zero) begin
				st_next.zero = alu_zero;
			end
			if (dec_dest_file) begin
				st_next.mem[file_index(dec_addr)] = alu_result;
			end else begin
				st_next.acc = alu_result;
			end
		end

		// Data phase: first cycle is a wait state, second completes
		if (st_reg.dph) begin
			if (!st_reg.ready) begin
				// Stall while an execution is due, so reads see its outcome
				if (!st_reg.pending) begin
					st_next.ready = 1'b1;
					if (!st_reg.dwrite) begin
						st_next.rdata = read_word(st_reg);
					end
				end
			end else begin
				st_next.dph = 1'b0;
				if (st_reg.dwrite) begin
					case (reg_offset(st_reg.daddr))
						OFS_INSTR: begin
							st_next.instr = hwdata_in[INSTR_W-1:0];
							st_next.pending = 1'b1;
						end
						OFS_ACC: st_next.acc = hwdata_in[DATA_W-1:0];
						OFS_STATUS: begin
							st_next.carry = hwdata_in[ST_CARRY];
							st_next.half = hwdata_in[ST_HALF];
							st_next.zero = hwdata_in[ST_ZERO];
						end
						OFS_FILE_PTR: st_next.file_ptr = hwdata_in[FILE_AW-1:0];
						OFS_FILE_DATA: begin
							st_next.mem[file_index(st_reg.file_ptr)] = hwdata_in[DATA_W-1:0];
						end
						// Read-only and unmapped offsets drop the write
						default: st_next.dph = 1'b0;
					endcase
				end
			end
		end

		// Address phase; may overlap the completing data phase
		if (addr_take) begin
			st_next.dph = 1'b1;
			st_next.dwrite = hwrite_in;
			st_next.daddr = haddr_in[7:0];
			st_next.ready = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs straight from the state flops
	assign hreadyout_out = st_reg.ready;
	assign hrdata_out = st_reg.rdata;
	assign hresp_out = st_reg.resp;

	// Datapath side, no logic between flop and pin
	assign acc_out = st_reg.acc;
	assign carry_out = st_reg.carry;
	assign half_carry_flag_out = st_reg.half;
	assign zero_out = st_reg.zero;
	assign busy_out = st_reg.pending;

endmodule // byte_alu_top
`default_nettype wire

// File: testbench/byte_alu_props.sv
// Checker of bus timing and of what may change the flags and accumulator
`timescale 1ns/1ps
`default_nettype none
module byte_alu_props
	import byte_alu_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic [BUS_W-1:0] hrdata_out,
	input wire logic hresp_out,
	input wire logic [DATA_W-1:0] acc_out,
	input wire logic carry_out,
	input wire logic half_carry_flag_out,
	input wire logic zero_out,
	input wire logic busy_out
);
	logic rdy_reg;
	logic done;
	logic taken;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// ====
	// Helpers, a transfer completes as ready rises
	assign taken = hsel_in && hready_in && htrans_in[1];
	assign done = hreadyout_out && !rdy_reg;
	always_ff @(posedge clock_in) begin
		rdy_reg <= hreadyout_out;
	end
	// ====
	// Bus handshake
	a_resp_okay: assert property (hresp_out == HRESP_OKAY)
		else $error("hresp not okay");
	a_wait_state: assert property (taken |=> !hreadyout_out)
		else $error("no wait state");
	a_wait_bound: assert property (!hreadyout_out |-> ##[1:2] hreadyout_out)
		else $error("wait too long");
	a_rdata_load: assert property ($changed(hrdata_out) |-> $rose(hreadyout_out))
		else $error("read data moved");
	// ====
	// Execution follows a completed write
	a_busy_pulse: assert property (busy_out |=> !busy_out)
		else $error("busy too long");
	a_busy_cause: assert property ($rose(busy_out) |-> $past(done))
		else $error("busy without write");
	a_flag_cause: assert property ($changed({carry_out, half_carry_flag_out, zero_out})
		|-> $past(busy_out) || $past(done)) else $error("flags moved alone");
	a_acc_cause: assert property ($changed(acc_out)
		|-> $past(busy_out) || $past(done)) else $error("acc moved alone");
endmodule // byte_alu_props
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the byte ALU top
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import byte_alu_pkg::*;
	logic clock_in = 1'h0;
	logic rst_in = 1'h1;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0] htrans_in = 2'h0;
	logic hwrite_in = 1'h0;
	logic [31:0] hwdata_in = 32'h0;
	logic hreadyout_out, hresp_out, carry_out, half_carry_flag_out, zero_out, busy_out;
	logic [31:0] hrdata_out;
	logic [7:0] acc_out;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	byte_alu_top dut_u (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.hsel_in(1'h1),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(3'h2),
		.hwdata_in(hwdata_in),
		.hready_in(hreadyout_out),
		.hreadyout_out(hreadyout_out),
		.hrdata_out(hrdata_out),
		.hresp_out(hresp_out),
		.acc_out(acc_out),
		.carry_out(carry_out),
		.half_carry_flag_out(half_carry_flag_out),
		.zero_out(zero_out),
		.busy_out(busy_out)
	);
	// ====
	// Clock and hang guard
	always #20 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end
	// ====
	// Bus tasks; entered just after a rising edge, ready sampled at rising edges
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		htrans_in <= 2'h2;
		haddr_in <= {24'h0, a};
		hwrite_in <= w;
		do @(posedge clock_in); while (hreadyout_out !== 1'h1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clock_in); while (hreadyout_out !== 1'h1);
		q = hrdata_out;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	// Preload operands, execute, then read every result place back
	task automatic do_op(input alu_op_t op, input logic d, input logic [6:0] a,
		input logic [7:0] w, input logic [7:0] f, input logic [7:0] k,
		input logic [2:0] st, input logic [7:0] er, input logic [2:0] es);
		logic fd;
		fd = d && (op != xor_literal_into_acc);
		wr(OFS_FILE_PTR, {25'h0, a});
		wr(OFS_FILE_DATA, {24'h0, f});
		wr(OFS_ACC, {24'h0, w});
		wr(OFS_STATUS, {29'h0, st});
		wr(OFS_INSTR, (op == xor_literal_into_acc) ? {22'h0, op, k} : {22'h0, op, d, a});
		@(posedge clock_in);
		chk("busy_out", 32'h00000001, {31'h0, busy_out});
		rd("acc", OFS_ACC, {24'h0, fd ? w : er});
		rd("file", OFS_FILE_DATA, {24'h0, fd ? er : f});
		rd("status", OFS_STATUS, {29'h0, es});
		rd("result", OFS_RESULT, {23'h0, fd, er});
		chk("acc_out", {24'h0, fd ? w : er}, {24'h0, acc_out});
		chk("flags_out", {29'h0, es}, {29'h0, zero_out, half_carry_flag_out, carry_out});
	endtask
	// ====
	// Scenarios
	task automatic t_idle;
		rd("acc", OFS_ACC, 32'h0);
		rd("status", OFS_STATUS, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF);
		rd("unmapped", 8'h1C, 32'h0);
		wr(OFS_RESULT, 32'h000000FF);
		rd("result", OFS_RESULT, 32'h0);
		rd("count", OFS_EXEC_CNT, 32'h0);
	endtask
	// Borrow cases on both halves, both ends of the file range
	task automatic t_sub;
		logic [7:0] ws[4] = '{8'h05, 8'h06, 8'h0F, 8'h11};
		logic [7:0] fs[4] = '{8'h05, 8'h05, 8'h10, 8'h02};
		logic [7:0] w;
		logic [7:0] f;
		for (int i = 0; i < 8; i++) begin
			w = ws[i % 4];
			f = fs[i % 4];
			do_op(subtract_acc_from_reg, i[2], {7{i[0]}}, w, f, 8'h00, {3{i[1]}}, f - w,
				{f == w, w[3:0] <= f[3:0], w <= f});
		end
	endtask
	task automatic t_xor;
		logic [7:0] f;
		logic [2:0] st;
		for (int i = 0; i < 4; i++) begin
			f = i[1] ? 8'h5A : 8'hC3;
			st = {1'h1, i[0], !i[0]};
			do_op(xor_acc_with_reg, i[0], 7'h40, 8'h5A, f, 8'h00, st, f ^ 8'h5A,
				{f == 8'h5A, st[1:0]});
		end
	endtask
	task automatic t_swap;
		for (int i = 0; i < 2; i++) begin
			do_op(nibble_exchange_reg, i[0], 7'h2A, 8'h3C, 8'hA5, 8'h00, {i[0], 1'h1, i[0]},
				8'h5A, {i[0], 1'h1, i[0]});
		end
	endtask
	// Literal bit 7 overlaps the select bit and must not redirect
	task automatic t_lit;
		logic [7:0] ks[4] = '{8'h00, 8'hFF, 8'h3C, 8'h80};
		for (int i = 0; i < 4; i++) begin
			do_op(xor_literal_into_acc, 1'h1, 7'h11, 8'h3C, 8'h99, ks[i], 3'h3,
				ks[i] ^ 8'h3C, {ks[i] == 8'h3C, 2'h3});
		end
	endtask
	task automatic final_report;
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ====
	// Main sequence
	initial begin
		repeat (5) @(posedge clock_in);
		rst_in <= 1'h0;
		t_idle();
		t_sub();
		t_xor();
		t_swap();
		t_lit();
		rd("count", OFS_EXEC_CNT, 32'h00000012);
		final_report();
	end
endmodule // testbench
bind byte_alu_top byte_alu_props chk_u (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.hsel_in(hsel_in),
	.htrans_in(htrans_in),
	.hready_in(hready_in),
	.hreadyout_out(hreadyout_out),
	.hrdata_out(hrdata_out),
	.hresp_out(hresp_out),
	.acc_out(acc_out),
	.carry_out(carry_out),
	.half_carry_flag_out(half_carry_flag_out),
	.zero_out(zero_out),
	.busy_out(busy_out)
);
`default_nettype wire
